// ==== hdl/energy_meter_pkg.sv ====
// Package: constants and types for the energy metering accumulator
package energy_meter_pkg;

  // Interval selection codes
  typedef enum logic [2:0] {
    INT_OFF,
    INT_5MIN,
    INT_10MIN,
    INT_15MIN,
    INT_30MIN,
    INT_60MIN
  } interval_t;

  localparam interval_t INTERVAL_RST = INT_30MIN;

  // Energy source selection
  typedef enum logic {
    SRC_MEASURE,
    SRC_PULSE
  } source_t;

  localparam source_t SOURCE_RST = SRC_MEASURE;

  // Reference direction
  typedef enum logic {
    DIR_DEMAND,
    DIR_SUPPLY
  } direction_t;

  localparam direction_t DIRECTION_RST = DIR_DEMAND;

  localparam int WEIGHT_W = 14;
  localparam logic [WEIGHT_W-1:0] WEIGHT_MIN = 14'h0001;
  localparam logic [WEIGHT_W-1:0] WEIGHT_MAX = 14'h2710;
  localparam logic [WEIGHT_W-1:0] WEIGHT_RST = 14'h0064;

  localparam int TOTAL_W = 48;
  localparam int POWER_W = 32;
  localparam int MINUTE_W = 6;
  localparam int HOUR_W = 5;

  // Settings word
  typedef struct packed {
    interval_t interval;
    source_t source;
    logic cumulative;
    direction_t direction;
    logic [WEIGHT_W-1:0] activeWeight;
    logic [WEIGHT_W-1:0] reactiveWeight;
    logic megaPrefix;
  } settings_t;

  localparam settings_t SETTINGS_RST = '{
    interval: INTERVAL_RST,
    source: SOURCE_RST,
    cumulative: 1'b0,
    direction: DIRECTION_RST,
    activeWeight: WEIGHT_RST,
    reactiveWeight: WEIGHT_RST,
    megaPrefix: 1'b0
  };

  // Four energy totals
  typedef struct packed {
    logic [TOTAL_W-1:0] activeDemand;
    logic [TOTAL_W-1:0] activeSupply;
    logic [TOTAL_W-1:0] reactiveDemand;
    logic [TOTAL_W-1:0] reactiveSupply;
  } totals_t;

  // Real-time clock position
  typedef struct packed {
    logic [HOUR_W-1:0] hour;
    logic [MINUTE_W-1:0] minute;
  } rtc_time_t;

  // Power sample per process cycle, signed
  typedef struct packed {
    logic signed [POWER_W-1:0] active;
    logic signed [POWER_W-1:0] reactive;
  } power_sample_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_START,
    ST_RUN
  } acc_state_t;

endpackage : energy_meter_pkg

// ==== hdl/energy_metering_accumulator.sv ====
// Energy metering accumulator: four totals, interval reporting, pulse and power input
// Summary of operation
// - Interval setting off, 5, 10, 15, 30, 60 min; default 30; off stops reporting.
// - Source selects internal power or external pulses; default internal power.
// - Clear input acts only in cumulative mode.
// - Reference direction demand or supply, default demand, picks demand sign.
// - Active and reactive pulse weights 1..10000, default 100, added per pulse.
// - Active demand and supply pulses counted only in pulse mode.
// - Reactive demand and supply pulses counted only in pulse mode.
// - Four running totals presented, with kilo or mega prefix from configuration.
// - At interval end, one event per total carrying value in Wh or VArh.
// - Interval boundaries align to the real-time clock from midnight.
// - Any setting change clears all four totals at once.
// - After a setting change, accumulation restarts at next aligned boundary.
// - First report after change at end of first complete interval.
// - Non-cumulative mode clears totals after each report; cumulative keeps adding.
// - Positive and negative contributions go to separate totals.
// - In-phase energy goes to reference direction total; opposite to the other.
`timescale 1ns/1ps
module energy_metering_accumulator
  import energy_meter_pkg::*;
#(
  parameter int TOTAL_BITS = TOTAL_W,
  parameter int SCALE_SHIFT = 0,
  parameter logic [31:0] MEGA_DIV = 32'h000003E8
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Settings
  input settings_t settings,
  // Real-time clock, minute tick pulse
  input rtc_time_t rtcTime,
  input wire logic rtcMinuteTick,
  // Measured power, one sample per process cycle
  input power_sample_t powerSample,
  input wire logic powerValid,
  // External meter pulses and clear input
  input wire logic active_demand_pulse_in,
  input wire logic active_supply_pulse_in,
  input wire logic reactive_demand_pulse_in,
  input wire logic reactive_supply_pulse_in,
  input wire logic totals_clear_in,
  // Running totals in energy units
  output totals_t totals,
  output logic megaPrefixOut,
  // Interval report events in Wh / VArh
  output totals_t eventValues,
  output logic eventValid,
  output logic accumulating
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection
  logic [4:0] rise;

  // One synchroniser per pin; bit 4 is the clear pin
  pin_rise_detect #(.IDLE_LEVEL(1'b0)) i_pin_rise_detect_0 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(active_demand_pulse_in),
    .rise(rise[0])
  );

  pin_rise_detect #(.IDLE_LEVEL(1'b0)) i_pin_rise_detect_1 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(active_supply_pulse_in),
    .rise(rise[1])
  );

  pin_rise_detect #(.IDLE_LEVEL(1'b0)) i_pin_rise_detect_2 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(reactive_demand_pulse_in),
    .rise(rise[2])
  );

  pin_rise_detect #(.IDLE_LEVEL(1'b0)) i_pin_rise_detect_3 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(reactive_supply_pulse_in),
    .rise(rise[3])
  );

  pin_rise_detect #(.IDLE_LEVEL(1'b0)) i_pin_rise_detect_4 (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pinIn(totals_clear_in),
    .rise(rise[4])
  );

  ////////////////////////////////////////////////////////////////////////////
  // Settings change and boundary detection
  settings_t setPrev_r, setPrev_nxt;
  logic setChanged;
  logic boundary;
  logic [MINUTE_W-1:0] period;

  always_comb begin
    unique case (settings.interval)
      INT_5MIN: period = 6'h05;
      INT_10MIN: period = 6'h0A;
      INT_15MIN: period = 6'h0F;
      INT_30MIN: period = 6'h1E;
      INT_60MIN: period = 6'h3C;
      default: period = 6'h00;
    endcase
    setPrev_nxt = settings;
    setChanged = (settings != setPrev_r);
    // Boundary on minute tick when minute-of-hour is a multiple of the period
    boundary = rtcMinuteTick && (period != 6'h00) &&
               ((period == 6'h3C) ? (rtcTime.minute == 6'h00) :
                (rtcTime.minute % period) == 6'h00);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      setPrev_r <= SETTINGS_RST;
    end else begin
      setPrev_r <= setPrev_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interval state machine
  acc_state_t state_r, state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (setChanged || settings.interval == INT_OFF) begin
      state_nxt = (settings.interval == INT_OFF) ? ST_IDLE : ST_WAIT_START;
    end else begin
      unique case (state_r)
        ST_IDLE: state_nxt = ST_WAIT_START;
        ST_WAIT_START: if (boundary) state_nxt = ST_RUN;
        ST_RUN: state_nxt = ST_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_WAIT_START;
    end else begin
      state_r <= state_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulation
  totals_t tot_r, tot_nxt;
  totals_t ev_r, ev_nxt;
  logic evValid_r, evValid_nxt;
  logic mega_r, mega_nxt;
  logic acc_r, acc_nxt;
  logic report;
  logic signed [POWER_W-1:0] pAct, pReact;
  logic [TOTAL_W-1:0] magAct, magReact;
  logic posAct, posReact;
  logic [TOTAL_W-1:0] wAct, wReact;

  function automatic logic [TOTAL_W-1:0] to_base(input logic [TOTAL_W-1:0] v, input logic mega);
    logic [TOTAL_W-1:0] k;
    k = mega ? TOTAL_W'(48'h0000000F4240) : TOTAL_W'(48'h0000000003E8);
    to_base = TOTAL_W'(v * k);
  endfunction : to_base

  // Weights outside the legal range are held at the nearest limit
  function automatic logic [WEIGHT_W-1:0] clamp_weight(input logic [WEIGHT_W-1:0] w);
    logic [WEIGHT_W-1:0] c;
    c = w;
    if (w < WEIGHT_MIN) begin
      c = WEIGHT_MIN;
    end
    if (w > WEIGHT_MAX) begin
      c = WEIGHT_MAX;
    end
    clamp_weight = c;
  endfunction : clamp_weight

  // A total stops at full scale rather than wrapping round to a small value
  function automatic logic [TOTAL_W-1:0] sat_add(input logic [TOTAL_W-1:0] a,
                                                input logic [TOTAL_W-1:0] b);
    logic [TOTAL_W:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[TOTAL_W] ? '1 : s[TOTAL_W-1:0];
  endfunction : sat_add

  always_comb begin
    report = (state_r == ST_RUN) && boundary && !setChanged;
    // Sign relative to the reference direction
    pAct = (settings.direction == DIR_DEMAND) ? powerSample.active
           : -powerSample.active;
    pReact = (settings.direction == DIR_DEMAND) ? powerSample.reactive
             : -powerSample.reactive;
    posAct = !pAct[POWER_W-1];
    posReact = !pReact[POWER_W-1];
    magAct = TOTAL_W'((posAct ? pAct : -pAct) >>> SCALE_SHIFT);
    magReact = TOTAL_W'((posReact ? pReact : -pReact) >>> SCALE_SHIFT);
    wAct = TOTAL_W'(clamp_weight(settings.activeWeight));
    wReact = TOTAL_W'(clamp_weight(settings.reactiveWeight));

    tot_nxt = tot_r;
    ev_nxt = ev_r;
    evValid_nxt = 1'b0;
    mega_nxt = settings.megaPrefix;
    acc_nxt = (state_nxt == ST_RUN);

    if (state_r == ST_RUN) begin
      if (settings.source == SRC_MEASURE) begin
        if (powerValid) begin
          if (posAct) tot_nxt.activeDemand = sat_add(tot_r.activeDemand, magAct);
          else tot_nxt.activeSupply = sat_add(tot_r.activeSupply, magAct);
          if (posReact) tot_nxt.reactiveDemand = sat_add(tot_r.reactiveDemand, magReact);
          else tot_nxt.reactiveSupply = sat_add(tot_r.reactiveSupply, magReact);
        end
      end else begin
        if (rise[0]) tot_nxt.activeDemand = sat_add(tot_r.activeDemand, wAct);
        if (rise[1]) tot_nxt.activeSupply = sat_add(tot_r.activeSupply, wAct);
        if (rise[2]) tot_nxt.reactiveDemand = sat_add(tot_r.reactiveDemand, wReact);
        if (rise[3]) tot_nxt.reactiveSupply = sat_add(tot_r.reactiveSupply, wReact);
      end
    end

    if (report) begin
      ev_nxt.activeDemand = to_base(tot_nxt.activeDemand, settings.megaPrefix);
      ev_nxt.activeSupply = to_base(tot_nxt.activeSupply, settings.megaPrefix);
      ev_nxt.reactiveDemand = to_base(tot_nxt.reactiveDemand, settings.megaPrefix);
      ev_nxt.reactiveSupply = to_base(tot_nxt.reactiveSupply, settings.megaPrefix);
      evValid_nxt = 1'b1;
      if (!settings.cumulative) tot_nxt = '0;
    end

    if (settings.cumulative && rise[4]) tot_nxt = '0;
    if (setChanged) tot_nxt = '0;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tot_r <= '0;
      ev_r <= '0;
      evValid_r <= 1'b0;
      mega_r <= 1'b0;
      acc_r <= 1'b0;
    end else begin
      tot_r <= tot_nxt;
      ev_r <= ev_nxt;
      evValid_r <= evValid_nxt;
      mega_r <= mega_nxt;
      acc_r <= acc_nxt;
    end
  end

  assign totals = tot_r;
  assign eventValues = ev_r;
  assign eventValid = evValid_r;
  assign megaPrefixOut = mega_r;
  assign accumulating = acc_r;

endmodule : energy_metering_accumulator

////////////////////////////////////////////////////////////////////////////
// Two-flop pin synchroniser with rising-edge detect
module pin_rise_detect
  import energy_meter_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b0
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Pin and detected edge
  input wire logic pinIn,
  output logic rise
);

  logic meta_r, meta_nxt;
  logic sync_r, sync_nxt;
  logic last_r, last_nxt;

  always_comb begin
    meta_nxt = pinIn;
    sync_nxt = meta_r;
    last_nxt = sync_r;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= IDLE_LEVEL;
      sync_r <= IDLE_LEVEL;
      last_r <= IDLE_LEVEL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
      last_r <= last_nxt;
    end
  end

  // Only the second stage feeds the detector, so one edge gives one count
  assign rise = sync_r & ~last_r;

endmodule : pin_rise_detect

// ==== tb/meter_pulse_model.sv ====
// Model of the external energy meter pulse outputs
`timescale 1ns/1ps
module meter_pulse_model (
  // Clock
  input wire logic clk_sys,
  // One-cycle requests, one bit per meter output
  input wire logic [3:0] fire,
  // Meter pulse outputs {active demand, active supply, reactive demand, reactive supply}
  output logic [3:0] pulseOut
);
  logic [3:0] hold = 4'h0;
  initial pulseOut = 4'h0;
  // Each request gives a two-cycle high pulse on its own output
  always @(posedge clk_sys) begin
    hold <= fire;
    pulseOut <= #1 fire | hold;
  end
endmodule : meter_pulse_model

// ==== tb/energy_metering_accumulator_sva.sv ====
// Checker: port-level properties of the energy metering accumulator
`timescale 1ns/1ps
module energy_metering_accumulator_sva
  import energy_meter_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Inputs watched
  input settings_t settings,
  input rtc_time_t rtcTime,
  input wire logic rtcMinuteTick,
  input wire logic totals_clear_in,
  // Outputs watched
  input totals_t totals,
  input wire logic eventValid,
  input wire logic accumulating
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////
  property p_ev_pulse; eventValid |=> !eventValid; endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event pulse too long");
  property p_chg_clr; $changed(settings) |=> totals == '0; endproperty
  a_chg_clr: assert property (p_chg_clr) else $error("totals kept on change");
  property p_off; settings.interval == INT_OFF [*2] |-> !accumulating && !eventValid; endproperty
  a_off: assert property (p_off) else $error("activity while off");
  property p_pin_clr;
    $rose(totals_clear_in) && settings.cumulative && $stable(settings) |-> ##[1:5] totals == '0;
  endproperty
  a_pin_clr: assert property (p_pin_clr) else $error("clear pin ignored");
  property p_rep_clr; eventValid && !settings.cumulative |-> totals == '0; endproperty
  a_rep_clr: assert property (p_rep_clr) else $error("totals kept after report");
  property p_bound;
    rtcMinuteTick && accumulating && rtcTime.minute == 6'h00 && settings.interval != INT_OFF
      && $stable(settings) |=> eventValid;
  endproperty
  a_bound: assert property (p_bound) else $error("no report at hour");
  property p_unaligned; rtcMinuteTick && rtcTime.minute == 6'h07 |=> !eventValid; endproperty
  a_unaligned: assert property (p_unaligned) else $error("report off boundary");
  property p_first; rtcMinuteTick && !accumulating && $stable(settings) |=> !eventValid; endproperty
  a_first: assert property (p_first) else $error("report at restart");
  ////////////////////////////////////////////////////////////
  c_report: cover property (eventValid);
  c_clear: cover property ($rose(totals_clear_in) && settings.cumulative);
  c_start: cover property (rtcMinuteTick && !accumulating ##1 accumulating);
endmodule : energy_metering_accumulator_sva

// ==== tb/energy_metering_accumulator_bench.sv ====
// Bench: directed tests for the energy metering accumulator
`timescale 1ns/1ps
module energy_metering_accumulator_bench
  import energy_meter_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_n;
  settings_t cfg, c;
  rtc_time_t rtc;
  power_sample_t ps;
  logic minTick, pv, clr, ev, acc, mega;
  logic [3:0] fire, pins;
  totals_t tot, evv;
  int mismatches = 0;
  int n_checks = 0;
  interval_t iv[4] = '{INT_5MIN, INT_10MIN, INT_15MIN, INT_60MIN};
  logic [5:0] mn[4] = '{6'h05, 6'h0A, 6'h0F, 6'h00};
  always #12.5 clk_sys = ~clk_sys;
  meter_pulse_model i_meter_pulse_model (.clk_sys(clk_sys), .fire(fire), .pulseOut(pins));
  energy_metering_accumulator i_energy_metering_accumulator (
    .clk_sys(clk_sys), .rst_n(rst_n), .settings(cfg), .rtcTime(rtc), .rtcMinuteTick(minTick),
    .powerSample(ps), .powerValid(pv), .active_demand_pulse_in(pins[3]),
    .active_supply_pulse_in(pins[2]), .reactive_demand_pulse_in(pins[1]),
    .reactive_supply_pulse_in(pins[0]), .totals_clear_in(clr), .totals(tot),
    .megaPrefixOut(mega), .eventValues(evv), .eventValid(ev), .accumulating(acc));
  ////////////////////////////////////////////////////////////
  task step(int n); repeat (n) @(posedge clk_sys); #1; endtask : step
  task chk(string n, logic [191:0] e, logic [191:0] g);
    n_checks++;
    if (e !== g) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task rtcTick(logic [5:0] m, logic expEv, logic expAcc);
    rtc.minute = m;
    minTick = 1'b1;
    step(1);
    minTick = 1'b0;
    chk("eventValid", expEv, ev);
    chk("accumulating", expAcc, acc);
    step(1);
  endtask : rtcTick
  task setcfg;
    cfg = c;
    step(1);
    chk("totals", '0, tot);
    chk("accumulating", 1'b0, acc);
  endtask : setcfg
  task pulse(logic [3:0] m); fire = m; step(1); fire = 4'h0; step(6); endtask : pulse
  task clear; clr = 1'b1; step(3); clr = 1'b0; step(4); endtask : clear
  ////////////////////////////////////////////////////////////
  initial begin
    cfg = SETTINGS_RST;
    c = SETTINGS_RST;
    rtc = '0;
    ps = '0;
    {minTick, pv, clr, fire, rst_n} = '0;
    step(10);
    rst_n = 1'b1;
    step(1);
    chk("totals", '0, tot);
    rtcTick(6'h07, 1'b0, 1'b0);
    rtcTick(6'h1E, 1'b0, 1'b1);
    ps = '{32'sh1F4, -32'sh12C};
    pv = 1'b1;
    step(1);
    pv = 1'b0;
    chk("totals", {48'h1F4, 48'h0, 48'h0, 48'h12C}, tot);
    pulse(4'hF);
    chk("totals", {48'h1F4, 48'h0, 48'h0, 48'h12C}, tot);
    c.direction = DIR_SUPPLY;
    setcfg();
    rtcTick(6'h00, 1'b0, 1'b1);
    pv = 1'b1;
    step(1);
    pv = 1'b0;
    chk("totals", {48'h0, 48'h1F4, 48'h12C, 48'h0}, tot);
    rtcTick(6'h1E, 1'b1, 1'b1);
    chk("eventValues", {48'h0, 48'h7A120, 48'h493E0, 48'h0}, evv);
    chk("megaPrefixOut", 1'b0, mega);
    chk("totals", '0, tot);
    $display("done: measurement");
    c.source = SRC_PULSE;
    c.cumulative = 1'b1;
    c.activeWeight = WEIGHT_MAX;
    c.reactiveWeight = WEIGHT_MIN;
    c.megaPrefix = 1'b1;
    setcfg();
    rtcTick(6'h00, 1'b0, 1'b1);
    pulse(4'hF);
    pulse(4'hF);
    chk("totals", {48'h4E20, 48'h4E20, 48'h2, 48'h2}, tot);
    rtcTick(6'h1E, 1'b1, 1'b1);
    chk("eventValues", {48'h4A817C800, 48'h4A817C800, 48'h1E8480, 48'h1E8480}, evv);
    chk("totals", {48'h4E20, 48'h4E20, 48'h2, 48'h2}, tot);
    chk("megaPrefixOut", 1'b1, mega);
    clear();
    chk("totals", '0, tot);
    c.cumulative = 1'b0;
    setcfg();
    rtcTick(6'h00, 1'b0, 1'b1);
    pulse(4'h8);
    clear();
    chk("totals", {48'h2710, 48'h0, 48'h0, 48'h0}, tot);
    $display("done: pulse mode");
    for (int k = 0; k < 4; k++) begin
      c.interval = iv[k];
      setcfg();
      rtcTick(6'h00, 1'b0, 1'b1);
      rtcTick(6'h07, 1'b0, 1'b1);
      rtcTick(mn[k], 1'b1, 1'b1);
    end
    c.interval = INT_OFF;
    setcfg();
    rtcTick(6'h00, 1'b0, 1'b0);
    $display("done: intervals");
    wrap_up();
  end
  // Cut a hung run short; the tests need well under a thousand cycles
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
endmodule : energy_metering_accumulator_bench

bind energy_metering_accumulator energy_metering_accumulator_sva i_sva (
  .clk_sys(clk_sys), .rst_n(rst_n), .settings(settings), .rtcTime(rtcTime),
  .rtcMinuteTick(rtcMinuteTick), .totals_clear_in(totals_clear_in), .totals(totals),
  .eventValid(eventValid), .accumulating(accumulating));
